// ---- line_side_model.sv ----
`timescale 1ns/1ns

// Far side of the block: receive FIFO status, transmitter status, flow
// character detector and the serial and modem pins, driven by bench commands.
module line_side_model (
  mclk,
  rst,
  rx_pop,
  go,
  cmd,
  err,
  rx_stat,
  tx_stat,
  flow_evt,
  rx_pin,
  modem_pins_n
);
  input  wire logic                     mclk;
  input  wire logic                     rst;
  input  wire logic                     rx_pop;   // Head character leaves.
  input  wire logic                     go;       // One-cycle command strobe.
  input  wire logic      [2:0]          cmd;      // Command code.
  input  wire logic      [2:0]          err;      // Errors of a pushed char.
  output uart_irq_pkg::rx_stat_t        rx_stat;
  output uart_irq_pkg::tx_stat_t        tx_stat;
  output uart_irq_pkg::flow_evt_t       flow_evt;
  output logic                          rx_pin;
  output logic           [4:0]          modem_pins_n;

  logic [2:0] errs [0:7];   // Error flags per stored character, head first.
  logic [6:0] level;        // Characters stored.
  logic       hold_empty;   // Transmit holding register empty.
  logic       rts_high;     // Flow pin released to its inactive level.
  logic       push_r;       // One-cycle push pulse.
  logic [2:0] push_err_r;   // Errors of the last pushed character.
  logic       overrun_r;    // One-cycle overrun pulse.

  // Status outputs; the receive line stays idle high so stale data ages.
  // The struct has one driver so no field mixes two kinds of assignment.
  assign rx_stat = '{level: level, above_trig: 1'b0, push: push_r,
                     push_err: push_err_r,
                     head_err: (level != 7'h00) ? errs[0] : 3'h0,
                     overrun: overrun_r, head_data: 8'hA5};
  assign tx_stat            = {hold_empty, 1'b0, 1'b1, 1'b1};
  assign rx_pin             = 1'b1;
  assign modem_pins_n       = {4'hF, rts_high};

  // A pop and a push never share a cycle in this bench, which keeps the
  // shift and the write index simple.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      level <= 7'h00;
      hold_empty <= 1'b0;
      rts_high <= 1'b0;
      push_r <= 1'b0;
      push_err_r <= 3'h0;
      overrun_r <= 1'b0;
      flow_evt <= 3'h0;
    end else begin
      push_r <= 1'b0;
      overrun_r <= 1'b0;
      flow_evt <= 3'h0;
      if (rx_pop && level != 7'h00) begin
        for (int i = 0; i < 7; i++) errs[i] <= errs[i+1];
        level <= level - 7'h01;
      end
      if (go) begin
        case (cmd)
          3'h0: begin
            errs[level[2:0]] <= err;
            level <= level + 7'h01;
            push_r <= 1'b1;
            push_err_r <= err;
          end
          3'h1: overrun_r <= 1'b1;
          3'h2: flow_evt.xoff <= 1'b1;
          3'h3: flow_evt.xon <= 1'b1;
          3'h4: flow_evt.special <= 1'b1;
          3'h5: hold_empty <= 1'b1;
          3'h6: hold_empty <= 1'b0;
          default: rts_high <= 1'b1;
        endcase
      end
    end
  end
endmodule

// ---- uart_interrupt_timeout_baud_logic_bench.sv ----
`timescale 1ns/1ns

// Self-checking bench: table-driven interrupt and baud cases, then hand tests.
module uart_interrupt_timeout_baud_logic_bench;
  logic        mclk = 1'b0;          // 25 MHz clock.
  logic        rst = 1'b1;           // Reset, high for 20 cycles.
  logic [3:0]  addr = 4'h0;          // Register offset.
  logic [7:0]  wdata = 8'h00;        // Write data.
  logic        wr = 1'b0;            // Write strobe.
  logic        rd = 1'b0;            // Read strobe.
  logic        fifo_en = 1'b0;       // FIFO mode select.
  logic        go = 1'b0;            // Model command strobe.
  logic [2:0]  cmd = 3'h0;           // Model command.
  logic [2:0]  err = 3'h0;           // Errors of a pushed character.
  logic [7:0]  rdata, tx_data, d;
  logic        rx_pop, tx_push, tx_pin, baud_tick, irq, rx_pin;
  logic [4:0]  modem_pins_n;
  uart_irq_pkg::rx_stat_t  rx_stat;
  uart_irq_pkg::tx_stat_t  tx_stat;
  uart_irq_pkg::flow_evt_t flow_evt;
  int          bad_count = 0;        // Mismatches seen.
  int          samples_checked = 0;  // Comparisons made.
  int          cycles = 0;           // Hang guard.
  int          n;
  logic [7:0]  ien_tab [0:4] = '{8'h02, 8'h04, 8'h40, 8'h20, 8'h01};
  logic [2:0]  cmd_tab [0:4] = '{3'h5, 3'h1, 3'h7, 3'h2, 3'h0};
  logic [7:0]  code_tab [0:4] = '{8'h02, 8'h06, 8'h20, 8'h10, 8'h04};
  logic [7:0]  lo_tab [0:3] = '{8'h05, 8'h05, 8'h00, 8'h01};
  logic [7:0]  hi_tab [0:3] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0]  mcr_tab [0:3] = '{8'h00, 8'h80, 8'h00, 8'h00};
  int          per_tab [0:3] = '{5, 20, 256, 1};

  always #20 mclk = ~mclk;

  uart_irq_baud DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo_en(fifo_en),
    .rx_stat(rx_stat), .tx_stat(tx_stat), .flow_evt(flow_evt),
    .rx_pin(rx_pin), .modem_pins_n(modem_pins_n), .rx_pop(rx_pop),
    .tx_push(tx_push), .tx_data(tx_data), .tx_pin(tx_pin),
    .baud_tick(baud_tick), .irq(irq));

  line_side_model far (.mclk(mclk), .rst(rst), .rx_pop(rx_pop), .go(go),
    .cmd(cmd), .err(err), .rx_stat(rx_stat), .tx_stat(tx_stat),
    .flow_evt(flow_evt), .rx_pin(rx_pin), .modem_pins_n(modem_pins_n));

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compares one value, with case equality so unknowns fail.
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // One-cycle register write.
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // One-cycle register read; data stand only in the following cycle.
  task rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // One command to the far-side model.
  task fire(input logic [2:0] c, input logic [2:0] e);
    @(posedge mclk);
    cmd <= c;
    err <= e;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  // Cycles between two baud ticks, bounded so a dead divider cannot hang.
  task period(output int p);
    int k;
    k = 0;
    #1;
    while (baud_tick !== 1'b1 && k < 600) begin
      @(posedge mclk);
      #1 k++;
    end
    @(posedge mclk);
    #1 p = 1;
    while (baud_tick !== 1'b1 && p < 600) begin
      @(posedge mclk);
      #1 p++;
    end
  endtask

  // Cuts a hang short; the whole run needs well under 5000 cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    #1 chk("irq at reset", 16'h0, irq);
    chk("tx_pin at reset", 16'h1, tx_pin);
    rd_reg(4'h2, d);
    chk("ident at reset", 16'h01, d);
    rd_reg(4'h1, d);
    chk("enable at reset", 16'h00, d);
    n = 0;
    repeat (100) begin
      @(posedge mclk);
      #1 n += baud_tick;
    end
    chk("ticks with zero divisor", 16'h0, n[15:0]);
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h7, lo_tab[i]);
      wr_reg(4'h8, hi_tab[i]);
      wr_reg(4'h4, mcr_tab[i]);
      period(n);
      chk("baud period", per_tab[i][15:0], n[15:0]);
    end
    for (int i = 0; i < 5; i++) begin
      wr_reg(4'h1, ien_tab[i]);
      fire(cmd_tab[i], 3'h0);
      repeat (5) @(posedge mclk);
      #1 chk("irq raised", 16'h1, irq);
      rd_reg(4'h2, d);
      chk("ident code", code_tab[i], d);
    end
    wr_reg(4'h1, 8'h00);
    #1 chk("irq polled", 16'h0, irq);
    rd_reg(4'h5, d);
    chk("polled data ready", 16'h1, d[0]);
    fire(3'h1, 3'h0);
    wr_reg(4'h1, 8'h27);
    rd_reg(4'h2, d);
    chk("highest first", 16'h06, d);
    rd_reg(4'h5, d);
    rd_reg(4'h2, d);
    chk("after status read", 16'h04, d);
    rd_reg(4'h0, d);
    rd_reg(4'h2, d);
    chk("after data read", 16'h10, d);
    fire(3'h3, 3'h0);
    repeat (2) @(posedge mclk);
    rd_reg(4'h2, d);
    chk("after xon", 16'h01, d);
    chk("irq idle", 16'h0, irq);
    fire(3'h4, 3'h0);
    rd_reg(4'h2, d);
    chk("special", 16'h10, d);
    rd_reg(4'h2, d);
    chk("special cleared", 16'h01, d);
    wr_reg(4'h1, 8'h04);
    fire(3'h0, 3'h4);
    fire(3'h0, 3'h0);
    rd_reg(4'h5, d);
    chk("errors in fifo", 16'h1, d[7]);
    chk("head errors", 16'h4, d[4:2]);
    rd_reg(4'h2, d);
    chk("error irq", 16'h06, d);
    rd_reg(4'h0, d);
    rd_reg(4'h5, d);
    chk("errors gone", 16'h1, {d[7], d[4:2], d[0]});
    rd_reg(4'h2, d);
    chk("error irq cleared", 16'h01, d);
    rd_reg(4'h0, d);
    rd_reg(4'h5, d);
    chk("empty head errors", 16'h0, d[4:2]);
    wr_reg(4'h1, 8'h02);
    fire(3'h6, 3'h0);
    fire(3'h5, 3'h0);
    wr_reg(4'h0, 8'h3C);
    #1 chk("tx push", 16'h13C, {tx_push, tx_data});
    rd_reg(4'h2, d);
    chk("write clears tx", 16'h01, d);
    wr_reg(4'h3, 8'h5D);
    repeat (2) @(posedge mclk);
    #1 chk("break low", 16'h0, tx_pin);
    wr_reg(4'h3, 8'h1D);
    repeat (2) @(posedge mclk);
    #1 chk("break ended", 16'h1, tx_pin);
    @(posedge mclk);
    fifo_en <= 1'b1;
    wr_reg(4'h1, 8'h01);
    fire(3'h0, 3'h0);
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("timeout delay", 16'h1, 16'(n >= 570 && n <= 590));
    rd_reg(4'h2, d);
    chk("timeout code", 16'hCC, d);
    @(posedge mclk);
    addr <= 4'h0;
    rd <= 1'b1;
    #1 chk("rx pop", 16'h1, rx_pop);
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("timeout cleared", 16'h0, irq);
    print_verdict();
  end
endmodule

// ---- uart_irq_baud.sv ----
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "uart_irq_consts.svh"

module uart_irq_baud #(
  parameter int DIV_W = 16
) (
  mclk,
  rst,
  ce,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  fifo_en,
  rx_stat,
  tx_stat,
  flow_evt,
  rx_pin,
  modem_pins_n,
  rx_pop,
  tx_push,
  tx_data,
  tx_pin,
  baud_tick,
  irq
);
  input  wire logic                    mclk;          // 25 MHz clock.
  input  wire logic                    rst;           // Async, high.
  input  wire logic                    ce;            // Freezes state.
  input  wire logic [3:0]              addr;
  input  wire logic [7:0]              wdata;
  input  wire logic                    wr;
  input  wire logic                    rd;
  output logic      [7:0]              rdata;
  input  wire logic                    fifo_en;
  input  wire uart_irq_pkg::rx_stat_t  rx_stat;
  input  wire uart_irq_pkg::tx_stat_t  tx_stat;
  input  wire uart_irq_pkg::flow_evt_t flow_evt;
  input  wire logic                    rx_pin;        // Serial input.
  input  wire logic [4:0]              modem_pins_n;  // cts,dsr,ri,cd,rts
  output logic                         rx_pop;
  output logic                         tx_push;
  output logic      [7:0]              tx_data;
  output logic                         tx_pin;
  output logic                         baud_tick;
  output logic                         irq;

  // Baud-tick count of a receive timeout for a word length code.
  function automatic logic [9:0] timeout_ticks(input logic [1:0] wl);
    logic [9:0] bits;
    bits = `TIMEOUT_WORD_MULT * (`WORD_LEN_BASE + {8'h00, wl})
         + `TIMEOUT_EXTRA_BITS;
    return 10'(bits * `TICKS_PER_BIT);
  endfunction

  // Software registers.
  logic [7:0]       irq_enable_reg;   // Per-type enables.
  logic [7:0]       line_ctrl_reg;    // Word length and break.
  logic [7:0]       modem_ctrl_reg;   // Prescaler select.
  logic [DIV_W-1:0] divisor_reg;      // Baud divisor.
  logic [7:0]       rdata_reg;        // Read data, one cycle late.
  // Sticky interrupt sources.
  logic             overrun_reg;
  logic             timeout_reg;
  logic             tx_irq_reg;
  logic             tx_cond_reg;      // Previous transmit condition.
  logic             xoff_reg;
  logic             special_reg;
  logic             rts_irq_reg;
  logic             cts_irq_reg;
  logic [3:0]       modem_delta_reg;
  logic [6:0]       err_count_reg;    // Erroneous chars in the FIFO.
  // Pin synchronisers.
  logic [5:0]       pin_meta_reg;
  logic [5:0]       pin_sync_reg;
  logic [5:0]       pin_prev_reg;
  // Baud generator and timeout counter.
  logic [1:0]       pre_cnt_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic             baud_tick_reg;
  logic [9:0]       to_cnt_reg;
  logic             tx_push_reg;
  logic [7:0]       tx_data_reg;
  logic             tx_pin_reg;

  // Decoded strobes.
  wire wr_hold   = wr && addr == `OFS_RX_TX_HOLD;
  wire rd_hold   = rd && addr == `OFS_RX_TX_HOLD;
  wire rd_ident  = rd && addr == `OFS_IRQ_IDENT;
  wire rd_lstat  = rd && addr == `OFS_LINE_STAT;
  wire rd_mstat  = rd && addr == `OFS_MODEM_STAT;
  wire wr_div_lo = wr && addr == `OFS_DIVISOR_LOW;
  wire wr_div_hi = wr && addr == `OFS_DIVISOR_HIGH;

  // Synchronised pins: index 5 is the serial input, 4..0 modem pins.
  wire       rx_line   = pin_sync_reg[5];
  wire [4:0] mpins_n   = pin_sync_reg[4:0];
  wire [4:0] mprev_n   = pin_prev_reg[4:0];
  wire       rx_empty  = rx_stat.level == 7'h00;

  // Line status; framing, parity and break flags read zero when the FIFO is empty.
  wire       any_err   = err_count_reg != 7'h00;
  wire [2:0] head_flag = rx_empty ? 3'h0 : rx_stat.head_err;
  wire [7:0] line_stat = {any_err, tx_stat.all_empty,
                          tx_stat.hold_empty, head_flag,
                          overrun_reg, !rx_empty};
  wire [7:0] modem_stat = {~mpins_n[4:1], modem_delta_reg};

  // Raw conditions of the interrupt types, each gated by its enable.
  wire ls_pend  = irq_enable_reg[`IEN_LINE_STAT]
                  && (overrun_reg || any_err);
  wire to_pend  = irq_enable_reg[`IEN_RX_DATA] && timeout_reg;
  wire rx_cond  = fifo_en ? rx_stat.above_trig : !rx_empty;
  wire rd_pend  = irq_enable_reg[`IEN_RX_DATA] && rx_cond;
  wire tx_cond  = fifo_en ? tx_stat.above_trig : tx_stat.hold_empty;
  wire tx_pend  = irq_enable_reg[`IEN_TX_EMPTY] && tx_irq_reg;
  wire ms_pend  = irq_enable_reg[`IEN_MODEM]
                  && modem_delta_reg != 4'h0;
  wire xo_pend  = irq_enable_reg[`IEN_XOFF]
                  && (xoff_reg || special_reg);
  wire fp_pend  = (irq_enable_reg[`IEN_RTS] && rts_irq_reg)
               || (irq_enable_reg[`IEN_CTS] && cts_irq_reg);

  // Priority encoder: only the highest pending type is reported.
  logic [5:0] ident_code;
  always_comb begin
    if (ls_pend) begin
      ident_code = `CODE_LINE_STAT;
    end else if (to_pend) begin
      ident_code = `CODE_RX_TIMEOUT;
    end else if (rd_pend) begin
      ident_code = `CODE_RX_DATA;
    end else if (tx_pend) begin
      ident_code = `CODE_TX_EMPTY;
    end else if (ms_pend) begin
      ident_code = `CODE_MODEM;
    end else if (xo_pend) begin
      ident_code = `CODE_XOFF_SPECIAL;
    end else if (fp_pend) begin
      ident_code = `CODE_FLOW_PIN;
    end else begin
      ident_code = `CODE_NONE;
    end
  end

  // Reading identification clears the types that clear on that read,
  // but only when that type is the one being reported.
  wire id_tx  = rd_ident && ident_code == `CODE_TX_EMPTY;
  wire id_xs  = rd_ident && ident_code == `CODE_XOFF_SPECIAL;
  wire id_fp  = rd_ident && ident_code == `CODE_FLOW_PIN;

  // Output is a plain OR of gated sources; no edge, no latching.
  assign irq = ident_code != `CODE_NONE;

  // Read multiplexer.
  logic [7:0] rd_mux;
  always_comb begin
    if (addr == `OFS_RX_TX_HOLD) begin
      rd_mux = rx_stat.head_data;
    end else if (addr == `OFS_IRQ_ENABLE) begin
      rd_mux = irq_enable_reg;
    end else if (addr == `OFS_IRQ_IDENT) begin
      rd_mux = {fifo_en, fifo_en, ident_code};
    end else if (addr == `OFS_LINE_CTRL) begin
      rd_mux = line_ctrl_reg;
    end else if (addr == `OFS_MODEM_CTRL) begin
      rd_mux = modem_ctrl_reg;
    end else if (addr == `OFS_LINE_STAT) begin
      rd_mux = line_stat;
    end else if (addr == `OFS_MODEM_STAT) begin
      rd_mux = modem_stat;
    end else if (addr == `OFS_DIVISOR_LOW) begin
      rd_mux = divisor_reg[7:0];
    end else if (addr == `OFS_DIVISOR_HIGH) begin
      rd_mux = divisor_reg[15:8];
    end else begin
      rd_mux = 8'h00;   // Unmapped offsets read as zero.
    end
  end

  // Pops are handshakes and leave combinationally with the read.
  assign rx_pop    = ce && rd_hold && !rx_empty;
  assign rdata     = rdata_reg;
  assign tx_push   = tx_push_reg;
  assign tx_data   = tx_data_reg;
  assign tx_pin    = tx_pin_reg;
  assign baud_tick = baud_tick_reg;

  // Baud generator terms. Prescaler runs every cycle when bypassed.
  wire pre_tick  = modem_ctrl_reg[`MCR_PRESCALE]
                   ? pre_cnt_reg == `PRESCALE_DIV : 1'b1;
  wire div_zero  = divisor_reg == '0;
  wire div_last  = div_cnt_reg >= divisor_reg - DIV_W'(1);
  wire div_write = wr_div_lo || wr_div_hi;

  // Timeout terms: any FIFO or line activity restarts the count.
  wire to_hold   = rx_empty || !rx_line || rx_stat.push || rx_pop;
  wire to_hit    = to_cnt_reg == timeout_ticks(line_ctrl_reg[1:0]);

  // Software registers. Divisor resets to zero, so no ticks at first.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_enable_reg <= `RST_IRQ_ENABLE;
      line_ctrl_reg  <= `RST_LINE_CTRL;
      modem_ctrl_reg <= `RST_MODEM_CTRL;
      divisor_reg    <= `RST_DIVISOR;
      rdata_reg      <= 8'h00;
      tx_push_reg    <= 1'b0;
      tx_data_reg    <= 8'h00;
    end else if (ce) begin
      if (wr && addr == `OFS_IRQ_ENABLE) irq_enable_reg <= wdata;
      if (wr && addr == `OFS_LINE_CTRL) line_ctrl_reg <= wdata;
      if (wr && addr == `OFS_MODEM_CTRL) modem_ctrl_reg <= wdata;
      if (wr_div_lo) divisor_reg[7:0] <= wdata;
      if (wr_div_hi) divisor_reg[15:8] <= wdata;
      if (rd) rdata_reg <= rd_mux;
      tx_push_reg <= wr_hold;
      if (wr_hold) tx_data_reg <= wdata;
    end
  end

  // Pin synchronisers; logic reads the second stage, and the third stage for edge detection.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 6'h3F;
      pin_sync_reg <= 6'h3F;
      pin_prev_reg <= 6'h3F;
    end else if (ce) begin
      pin_meta_reg <= {rx_pin, modem_pins_n};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Stored error count: each erroneous push adds, erroneous pop takes.
  wire err_in  = rx_stat.push && rx_stat.push_err != 3'h0;
  wire err_out = rx_pop && rx_stat.head_err != 3'h0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_count_reg <= 7'h00;
    end else if (ce && err_in != err_out) begin
      err_count_reg <= err_in ? err_count_reg + 7'h01
                              : err_count_reg - 7'h01;
    end
  end

  // Sticky sources. In every flag the set outranks the clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overrun_reg     <= 1'b0;
      tx_irq_reg      <= 1'b0;
      tx_cond_reg     <= 1'b0;
      xoff_reg        <= 1'b0;
      special_reg     <= 1'b0;
      rts_irq_reg     <= 1'b0;
      cts_irq_reg     <= 1'b0;
      modem_delta_reg <= 4'h0;
    end else if (ce) begin
      overrun_reg <= rx_stat.overrun || (overrun_reg && !rd_lstat);
      tx_cond_reg <= tx_cond;
      tx_irq_reg  <= (tx_cond && !tx_cond_reg)
                  || (tx_irq_reg && !id_tx && !wr_hold);
      xoff_reg    <= flow_evt.xoff || (xoff_reg && !flow_evt.xon);
      special_reg <= flow_evt.special || (special_reg && !id_xs);
      rts_irq_reg <= (mpins_n[0] && !mprev_n[0])
                  || (rts_irq_reg && !id_fp);
      cts_irq_reg <= (mpins_n[4] && !mprev_n[4])
                  || (cts_irq_reg && !id_fp);
      modem_delta_reg <= (mpins_n[4:1] ^ mprev_n[4:1])
                      | (modem_delta_reg & {4{!rd_mstat}});
    end
  end

  // Receive timeout counts baud ticks while the line idles high.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      to_cnt_reg  <= 10'h000;
      timeout_reg <= 1'b0;
    end else if (ce) begin
      if (to_hold) begin
        to_cnt_reg <= 10'h000;
      end else if (baud_tick_reg && !to_hit) begin
        to_cnt_reg <= to_cnt_reg + 10'h001;
      end
      timeout_reg <= (!to_hold && to_hit)
                  || (timeout_reg && !rd_hold && !rx_empty);
    end
  end

  // Baud divider. A rewrite restarts the count so the new rate takes
  // hold at once rather than after a stale long period.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_cnt_reg   <= 2'h0;
      div_cnt_reg   <= '0;
      baud_tick_reg <= 1'b0;
    end else if (ce) begin
      pre_cnt_reg   <= pre_cnt_reg + 2'h1;
      baud_tick_reg <= 1'b0;
      if (div_write || div_zero) begin
        div_cnt_reg <= '0;
        pre_cnt_reg <= 2'h0;
      end else if (pre_tick) begin
        if (div_last) begin
          div_cnt_reg   <= '0;
          baud_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + DIV_W'(1);
        end
      end
    end
  end

  // Transmit pin is registered; break holds it low while set.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_pin_reg <= 1'b1;
    end else if (ce) begin
      tx_pin_reg <= line_ctrl_reg[`LCR_BREAK] ? 1'b0
                                              : tx_stat.serial;
    end
  end

  // Checks.
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  idle_code_a: assert property (
    !ls_pend && !to_pend && !rd_pend && !tx_pend && !ms_pend
    && !xo_pend && !fp_pend |-> ident_code == 6'h01 && !irq)
    else $error("idle ident code wrong");
  ls_first_a: assert property (ls_pend |-> ident_code == 6'h06)
    else $error("line status not highest");
  zero_en_a: assert property (irq_enable_reg == 8'h00 |-> !irq)
    else $error("interrupt with all enables clear");
  break_low_a: assert property (
    ce && line_ctrl_reg[6] |=> !tx_pin)
    else $error("break did not drive line low");
  no_tick_a: assert property (
    divisor_reg == 16'h0000 && $past(divisor_reg) == 16'h0000
    |-> !baud_tick)
    else $error("tick with zero divisor");
  // A divisor of one without the prescaler ticks every cycle by design.
  tick_single_a: assert property (
    baud_tick && $stable(modem_ctrl_reg)
    && (divisor_reg != 16'h0001 || modem_ctrl_reg[7]) |=> !baud_tick)
    else $error("tick longer than one cycle");
  div_one_a: assert property (
    ce && divisor_reg == 16'h0001 && !modem_ctrl_reg[7]
    && $stable(divisor_reg) && !div_write |=> baud_tick)
    else $error("divisor one does not tick each cycle");
  pre_gap_a: assert property (
    baud_tick && modem_ctrl_reg[7] |=> !baud_tick [*3])
    else $error("prescaler gap too short");
  xoff_set_a: assert property (ce && flow_evt.xoff |=> xoff_reg)
    else $error("xoff not recorded");
  head_zero_a: assert property (
    rx_empty |-> line_stat[4:2] == 3'h0)
    else $error("error bits with empty fifo");
  tx_clear_a: assert property (
    ce && tx_irq_reg && wr_hold && !(tx_cond && !tx_cond_reg)
    |=> !tx_irq_reg)
    else $error("transmit source not cleared by write");

endmodule

// ---- uart_irq_consts.svh ----
`ifndef UART_IRQ_CONSTS_SVH
`define UART_IRQ_CONSTS_SVH

// Register offsets on the plain register port.
`define OFS_RX_TX_HOLD     4'h0
`define OFS_IRQ_ENABLE     4'h1
`define OFS_IRQ_IDENT      4'h2
`define OFS_LINE_CTRL      4'h3
`define OFS_MODEM_CTRL     4'h4
`define OFS_LINE_STAT      4'h5
`define OFS_MODEM_STAT     4'h6
`define OFS_DIVISOR_LOW    4'h7
`define OFS_DIVISOR_HIGH   4'h8

// Reset values.
`define RST_IRQ_ENABLE     8'h00
`define RST_LINE_CTRL      8'h1D
`define RST_MODEM_CTRL     8'h00
`define RST_DIVISOR        16'h0000

// Identification codes, low six bits of the identification register.
`define CODE_NONE          6'h01
`define CODE_LINE_STAT     6'h06
`define CODE_RX_TIMEOUT    6'h0C
`define CODE_RX_DATA       6'h04
`define CODE_TX_EMPTY      6'h02
`define CODE_MODEM         6'h00
`define CODE_XOFF_SPECIAL  6'h10
`define CODE_FLOW_PIN      6'h20

// Interrupt enable field positions.
`define IEN_RX_DATA        0
`define IEN_TX_EMPTY       1
`define IEN_LINE_STAT      2
`define IEN_MODEM          3
`define IEN_XOFF           5
`define IEN_RTS            6
`define IEN_CTS            7

// Control field positions.
`define LCR_BREAK          6
`define MCR_PRESCALE       7

// Timing counts.
`define PRESCALE_DIV       2'd3
`define TICKS_PER_BIT      10'd16
`define TIMEOUT_WORD_MULT  10'd4
`define TIMEOUT_EXTRA_BITS 10'd12
`define WORD_LEN_BASE      10'd5

`endif

// ---- uart_irq_pkg.sv ----
package uart_irq_pkg;

  // Status of the receive FIFO, on the same clock as this block.
  typedef struct packed {
    logic [6:0] level;       // Characters held; zero means empty.
    logic       above_trig;  // Level is above the receive trigger.
    logic       push;        // One-cycle pulse: a character entered.
    logic [2:0] push_err;    // Framing, parity, break of pushed char.
    logic [2:0] head_err;    // Framing, parity, break of head char.
    logic       overrun;     // One-cycle pulse: a character was lost.
    logic [7:0] head_data;   // Character at the head of the FIFO.
  } rx_stat_t;

  // Status of the transmit side.
  typedef struct packed {
    logic hold_empty;  // Transmit holding register or FIFO empty.
    logic above_trig;  // Transmit FIFO passed its trigger level.
    logic all_empty;   // Holding and shift register both empty.
    logic serial;      // Serial bit from the transmit shifter.
  } tx_stat_t;

  // One-cycle flow character detections.
  typedef struct packed {
    logic xoff;
    logic xon;
    logic special;
  } flow_evt_t;

endpackage
